// ==== logic/fnm_pkg.sv ====
// package: constants, states and frame layout shared by both ends
package fnm_pkg;
    localparam int         ID_W        = 11;
    localparam logic [10:0] ID_NMT     = 11'h000;
    localparam logic [10:0] ID_SYNC    = 11'h080;
    localparam logic [10:0] ID_EMCY    = 11'h080;
    localparam logic [10:0] ID_TPDO1   = 11'h180;
    localparam logic [10:0] ID_RPDO1   = 11'h200;
    localparam logic [10:0] ID_PDO_STEP = 11'h100;
    localparam logic [10:0] ID_SDO_TX  = 11'h580;
    localparam logic [10:0] ID_SDO_RX  = 11'h600;
    localparam logic [10:0] ID_BOOT    = 11'h700;
    localparam logic [3:0]  NMT_DLC    = 4'h2;
    localparam logic [7:0]  CMD_OPER   = 8'h01;
    localparam logic [7:0]  CMD_STOP   = 8'h02;
    localparam logic [7:0]  CMD_PREOP  = 8'h80;
    localparam logic [7:0]  CMD_RST_NODE = 8'h81;
    localparam logic [7:0]  CMD_RST_COMM = 8'h82;
    localparam logic [7:0]  NODE_BCAST = 8'h00;
    localparam logic [6:0]  NODE_MIN   = 7'h01;
    localparam int          INIT_CYCLES = 4;
    localparam logic [2:0]  INIT_CNT_RST = 3'h0;

    typedef enum logic [1:0] {
        FNM_INIT,
        FNM_PREOP,
        FNM_OPER,
        FNM_STOP
    } fnm_state_t;
endpackage : fnm_pkg

// ==== logic/fnm_link_if.sv ====
// interface: one received frame, standard or extended by ext_id, from master to slave
`timescale 1ns/100ps
interface fnm_link_if;
    logic        valid;
    logic        ext_id;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;

    modport master (output valid, output ext_id, output id, output dlc,
                    output data);
    modport slave  (input valid, input ext_id, input id, input dlc,
                    input data);
endinterface : fnm_link_if

// ==== logic/fnm_slave.sv ====
// network-management slave: command decode, state machine, service gating
// Function
// - only standard 11-bit identifiers are used
// - payload values go least significant byte first
// - slave obeys commands of single master
// - node identifier 1 to 127 selects commands
// - initialization only at power-up or reset
// - initialization ends in pre-operational automatically
// - startup setting auto-advances to operational
// - stopped suppresses all but network management
// - services gated per state table
// - frames on identifier 0, two bytes
// - command codes 01 02 80 81 82
// - node reset full, comm reset comm only
// - target 00 broadcasts, else identifier match
// - default identifier map per service
`timescale 1ns/100ps
module fnm_slave (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    fnm_link_if.slave                link,
    input  wire logic [6:0]          node_id,
    input  wire logic                auto_start,
    output logic [1:0]               nmt_state,
    output logic                     pdo_en,
    output logic                     sdo_en,
    output logic                     sync_en,
    output logic                     emcy_en,
    output logic                     boot_en,
    output logic                     boot_send,
    output logic                     node_reset,
    output logic                     comm_reset,
    output logic [10:0]              id_emcy,
    output logic [10:0]              id_tpdo1,
    output logic [10:0]              id_rpdo1,
    output logic [10:0]              id_sdo_tx,
    output logic [10:0]              id_sdo_rx,
    output logic [10:0]              id_boot
);
    // every bit of state lives in this one record
    typedef struct packed {
        fnm_pkg::fnm_state_t state;
        logic [2:0]          init_cnt;
        logic [6:0]          node_meta;
        logic [6:0]          node_sync;
        logic                auto_meta;
        logic                auto_sync;
        logic [6:0]          node;
        logic                auto_run;
        logic                auto_done;
        logic                pdo_en;
        logic                sdo_en;
        logic                sync_en;
        logic                emcy_en;
        logic                boot_en;
        logic                boot_send;
        logic                node_reset;
        logic                comm_reset;
        logic [10:0]         id_emcy;
        logic [10:0]         id_tpdo1;
        logic [10:0]         id_rpdo1;
        logic [10:0]         id_sdo_tx;
        logic [10:0]         id_sdo_rx;
        logic [10:0]         id_boot;
    } fnm_slv_t;

    fnm_slv_t r;
    fnm_slv_t next_r;
    logic     nmt_hit;
    logic     for_me;
    logic [7:0] cmd;
    logic [7:0] tgt;

    // byte 0 is the command, byte 1 the target node
    assign cmd = link.data[7:0];
    assign tgt = link.data[15:8];

    // a frame is ours if standard id 0, length two, and addressed here
    assign for_me  = (tgt == fnm_pkg::NODE_BCAST) ||
                     (tgt == {1'b0, r.node});
    assign nmt_hit = link.valid && !link.ext_id &&
                     (link.id == fnm_pkg::ID_NMT) &&
                     (link.dlc == fnm_pkg::NMT_DLC) && for_me;

    // next state and gating
    always_comb
    begin
        next_r = r;
        // straps come from pins; two flip-flops before any use
        // a switch may move at any time, the copies hold off metastability
        next_r.node_meta  = node_id;
        next_r.node_sync  = r.node_meta;
        next_r.auto_meta  = auto_start;
        next_r.auto_sync  = r.auto_meta;
        next_r.boot_send  = 1'b0;
        next_r.node_reset = 1'b0;
        next_r.comm_reset = 1'b0;
        unique case (r.state)
            fnm_pkg::FNM_INIT:
            begin
                if (r.init_cnt == 3'(fnm_pkg::INIT_CYCLES - 1))
                begin
                    next_r.state     = fnm_pkg::FNM_PREOP;
                    next_r.boot_send = 1'b1;
                    next_r.init_cnt  = fnm_pkg::INIT_CNT_RST;
                    // straps are taken as initialization ends
                    // a zero strap is no legal node, node 1 stands in
                    next_r.node      = (r.node_sync == 7'h00) ?
                                       fnm_pkg::NODE_MIN : r.node_sync;
                    next_r.auto_run  = r.auto_sync;
                end
                else
                begin
                    next_r.init_cnt = r.init_cnt + 3'h1;
                end
            end
            default:
            begin
                // auto-start fires once per initialization
                if (r.state == fnm_pkg::FNM_PREOP && r.auto_run &&
                    !r.auto_done)
                begin
                    next_r.state     = fnm_pkg::FNM_OPER;
                    next_r.auto_done = 1'b1;
                end
                // only network-management acts outside init
                // frames during initialization are dropped by the state case
                if (nmt_hit)
                begin
                    unique case (cmd)
                        fnm_pkg::CMD_OPER:
                            next_r.state = fnm_pkg::FNM_OPER;
                        fnm_pkg::CMD_STOP:
                            next_r.state = fnm_pkg::FNM_STOP;
                        fnm_pkg::CMD_PREOP:
                            next_r.state = fnm_pkg::FNM_PREOP;
                        // a reset command re-runs initialization and straps
                        fnm_pkg::CMD_RST_NODE:
                        begin
                            next_r.state      = fnm_pkg::FNM_INIT;
                            next_r.node_reset = 1'b1;
                            next_r.auto_done  = 1'b0;
                        end
                        fnm_pkg::CMD_RST_COMM:
                        begin
                            next_r.state      = fnm_pkg::FNM_INIT;
                            next_r.comm_reset = 1'b1;
                            next_r.auto_done  = 1'b0;
                        end
                        // unknown codes leave state and auto-start alone
                        default:
                        begin
                        end
                    endcase
                end
            end
        endcase
        // service gating from the state being entered
        next_r.pdo_en  = (next_r.state == fnm_pkg::FNM_OPER);
        next_r.sdo_en  = (next_r.state == fnm_pkg::FNM_PREOP) ||
                         (next_r.state == fnm_pkg::FNM_OPER);
        next_r.sync_en = next_r.sdo_en;
        next_r.emcy_en = next_r.sdo_en;
        next_r.boot_en = (next_r.state == fnm_pkg::FNM_INIT);
        // default identifier map for this node
        // built from the node being entered, so it never lags a change
        next_r.id_emcy   = fnm_pkg::ID_EMCY   + {4'h0, next_r.node};
        next_r.id_tpdo1  = fnm_pkg::ID_TPDO1  + {4'h0, next_r.node};
        next_r.id_rpdo1  = fnm_pkg::ID_RPDO1  + {4'h0, next_r.node};
        next_r.id_sdo_tx = fnm_pkg::ID_SDO_TX + {4'h0, next_r.node};
        next_r.id_sdo_rx = fnm_pkg::ID_SDO_RX + {4'h0, next_r.node};
        next_r.id_boot   = fnm_pkg::ID_BOOT   + {4'h0, next_r.node};
    end

    // state register; power-up reset starts initialization
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            r          <= '0;
            r.state    <= fnm_pkg::FNM_INIT;
            r.node     <= fnm_pkg::NODE_MIN;
            r.boot_en  <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs are taken straight from the state register
    assign nmt_state  = r.state;
    assign pdo_en     = r.pdo_en;
    assign sdo_en     = r.sdo_en;
    assign sync_en    = r.sync_en;
    assign emcy_en    = r.emcy_en;
    assign boot_en    = r.boot_en;
    assign boot_send  = r.boot_send;
    assign node_reset = r.node_reset;
    assign comm_reset = r.comm_reset;
    assign id_emcy    = r.id_emcy;
    assign id_tpdo1   = r.id_tpdo1;
    assign id_rpdo1   = r.id_rpdo1;
    assign id_sdo_tx  = r.id_sdo_tx;
    assign id_sdo_rx  = r.id_sdo_rx;
    assign id_boot    = r.id_boot;
endmodule : fnm_slave

// ==== logic/fnm_master.sv ====
// network-management master end: builds two-byte command frames
`timescale 1ns/100ps
module fnm_master (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    fnm_link_if.master               link,
    input  wire logic                cmd_req,
    input  wire logic [7:0]          cmd_code,
    input  wire logic [6:0]          cmd_node,
    output logic                     cmd_done
);
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic        done;
    } fnm_mst_t;

    fnm_mst_t r;
    fnm_mst_t next_r;

    // one frame per cycle that cmd_req is high, command then node, lsb first
    always_comb
    begin
        next_r       = r;
        next_r.valid = 1'b0;
        next_r.done  = 1'b0;
        if (cmd_req)
        begin
            next_r.valid = 1'b1;
            next_r.data  = {48'h0, 1'b0, cmd_node, cmd_code};
            next_r.done  = 1'b1;
        end
    end

    // frame register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    assign link.valid  = r.valid;
    assign link.ext_id = 1'b0;
    assign link.id     = fnm_pkg::ID_NMT;
    assign link.dlc    = fnm_pkg::NMT_DLC;
    assign link.data   = r.data;
    assign cmd_done    = r.done;
endmodule : fnm_master

// ==== testbench/fnm_assertions.sv ====
// checker: frame format on the link and state gating of the slave
`timescale 1ns/100ps
module fnm_assertions (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        valid,
    input wire logic        ext_id,
    input wire logic [10:0] id,
    input wire logic [3:0]  dlc,
    input wire logic [63:0] data,
    input wire logic [1:0]  nmt_state,
    input wire logic        pdo_en,
    input wire logic        sdo_en,
    input wire logic        boot_en,
    input wire logic        sync_en,
    input wire logic        emcy_en,
    input wire logic        boot_send
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // frames from the master end
    a_std_id_only: assert property (valid |-> !ext_id)
        else $error("extended identifier on link");
    a_frame_format: assert property (valid |-> id == 11'h000 &&
        dlc == 4'h2) else $error("command frame identifier or length wrong");
    a_cmd_known: assert property (valid |-> data[7:0] inside
        {8'h01, 8'h02, 8'h80, 8'h81, 8'h82}) else $error("unknown command");
    a_target_range: assert property (valid |-> !data[15])
        else $error("target node above range");
    // service gating by state
    a_pdo_gate: assert property (pdo_en == (nmt_state == 2'h2))
        else $error("process data enable wrong for state");
    a_sdo_gate: assert property (sdo_en ==
        (nmt_state inside {2'h1, 2'h2}))
        else $error("service data enable wrong for state");
    a_boot_gate: assert property (boot_en == (nmt_state == 2'h0))
        else $error("boot enable wrong for state");
    a_sync_gate: assert property (sync_en == emcy_en &&
        sync_en == (nmt_state inside {2'h1, 2'h2}))
        else $error("sync or emergency enable wrong for state");
    // state transitions
    a_boot_pulse: assert property (boot_send == (nmt_state == 2'h1 &&
        $past(nmt_state) == 2'h0))
        else $error("boot-up pulse not on leaving initialization");
    a_init_exit: assert property (nmt_state == 2'h0 |->
        ##[1:6] nmt_state != 2'h0)
        else $error("initialization does not end");
    a_bcast_start: assert property (valid && data[15:0] == 16'h0001 &&
        nmt_state != 2'h0 |=> nmt_state == 2'h2) else $error("broadcast start lost");
    a_init_cause: assert property (nmt_state != 2'h0 && !(valid &&
        data[7:0] inside {8'h81, 8'h82}) |=> nmt_state != 2'h0)
        else $error("initialization without reset command");
    c_oper: cover property (nmt_state == 2'h2);
    c_stop: cover property (nmt_state == 2'h3);
    c_reset_cmd: cover property (valid && data[7:0] == 8'h82);
endmodule : fnm_assertions

// ==== testbench/testbench.sv ====
// testbench: command sequences through both ends, rule-breaking link
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
    localparam logic [6:0] NID = 7'h05;
    // {code, node, settle, state, node_reset, comm_reset}
    localparam logic [19:0] CT [9] = '{20'h010a8, 20'h0200c, 20'h010cc,
        20'h800a4, 20'h01008, 20'h82001, 20'h01014, 20'h810a2, 20'h80014};
    // {extended, identifier, length, payload}
    localparam logic [31:0] BT [8] = '{32'h80020002, 32'h00030002,
        32'h00010002, 32'h00120002, 32'h00020003, 32'h00020202, 32'h00020102,
        32'h00020180};
    logic        ref_clk;
    logic        reset;
    logic        cmd_req;
    logic [7:0]  cmd_code;
    logic [6:0]  cmd_node;
    logic        cmd_done;
    logic [1:0]  st;
    logic [1:0]  st2;
    logic        pdo;
    logic        sdo;
    logic        boot;
    logic        sync;
    logic        emcy;
    logic        bsend;
    logic [1:0]  es;
    logic        nrst;
    logic        crst;
    logic [10:0] i_em, i_tp, i_rp, i_st, i_sr, i_bt, sdo2;
    int          n_fail, tests_run, cyc;
    fnm_link_if  link ();
    fnm_link_if  bad ();

    // both ends joined, plus a second slave fed by the bench
    fnm_master fnm_master_i (.ref_clk, .reset, .link(link.master), .cmd_req,
        .cmd_code, .cmd_node, .cmd_done);
    fnm_slave fnm_slave_i (.ref_clk, .reset, .link(link.slave),
        .node_id(NID), .auto_start(1'b0), .nmt_state(st), .pdo_en(pdo),
        .sdo_en(sdo), .sync_en(sync), .emcy_en(emcy), .boot_en(boot),
        .boot_send(bsend),
        .node_reset(nrst), .comm_reset(crst), .id_emcy(i_em),
        .id_tpdo1(i_tp), .id_rpdo1(i_rp), .id_sdo_tx(i_st),
        .id_sdo_rx(i_sr), .id_boot(i_bt));
    fnm_slave fnm_slave_i2 (.ref_clk, .reset, .link(bad.slave),
        .node_id(7'h00), .auto_start(1'b1), .nmt_state(st2), .pdo_en(),
        .sdo_en(), .sync_en(), .emcy_en(), .boot_en(), .boot_send(),
        .node_reset(), .comm_reset(), .id_emcy(), .id_tpdo1(), .id_rpdo1(),
        .id_sdo_tx(sdo2), .id_sdo_rx(), .id_boot());
    fnm_assertions fnm_assertions_i (.ref_clk, .reset, .valid(link.valid),
        .ext_id(link.ext_id), .id(link.id), .dlc(link.dlc), .data(link.data),
        .nmt_state(st), .pdo_en(pdo), .sdo_en(sdo), .boot_en(boot),
        .sync_en(sync), .emcy_en(emcy), .boot_send(bsend));

    // clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // one command through the master end, frame checked on the wire
    task automatic send(input logic [7:0] c, input logic [6:0] n);
        int k;
        @(posedge ref_clk) #1;
        cmd_req = 1'b1;
        cmd_code = c;
        cmd_node = n;
        k = 0;
        do
        begin
            @(posedge ref_clk) #1;
            k++;
        end while (cmd_done !== 1'b1 && k < 8);
        cmd_req = 1'b0;
        `CHK("frame", {2'h2, 11'h000, 4'h2, 1'b0, n, c},
            {link.valid, link.ext_id, link.id, link.dlc,
            link.data[15:0]})
        @(posedge ref_clk) #1;
    endtask : send

    // one raw frame on the second link, data lines scrambled afterwards
    task automatic poke(input logic [31:0] f);
        @(posedge ref_clk) #1;
        {bad.ext_id, bad.id, bad.dlc} = f[31:16];
        bad.data = {48'h0, f[15:0]};
        bad.valid = 1'b1;
        @(posedge ref_clk) #1;
        bad.valid = 1'b0;
        bad.data = ~bad.data;
        @(posedge ref_clk) #1;
    endtask : poke

    // main sequence
    initial
    begin
        reset = 1'b1;
        cmd_req = 1'b0;
        cmd_code = 8'h00;
        cmd_node = 7'h00;
        bad.valid = 1'b0;
        bad.ext_id = 1'b0;
        bad.id = 11'h000;
        bad.dlc = 4'h0;
        bad.data = 64'h0;
        repeat (5) @(posedge ref_clk);
        #1 reset = 1'b0;
        `CHK("init", {2'h0, 1'b1}, {st, boot})
        #80;
        `CHK("preop", {2'h1, 2'h1, 2'h2}, {st, pdo, sdo, st2})
        `CHK("ids", {11'h085, 11'h185, 11'h205, 11'h585, 11'h605, 11'h705}, {i_em, i_tp, i_rp, i_st, i_sr, i_bt})
        `CHK("ids2", 11'h581, sdo2)
        for (int i = 0; i < 9; i++)
        begin
            send(CT[i][19:12], CT[i][11:5]);
            if (CT[i][4])
                #60;
            es = CT[i][3:2];
            `CHK("state", {es, es == 2'h2, {3{es inside {2'h1, 2'h2}}},
                es == 2'h0, CT[i][1:0]}, {st, pdo, sdo, sync, emcy,
                boot, nrst, crst})
        end
        for (int i = 0; i < 8; i++)
        begin
            poke(BT[i]);
            es = (i == 7) ? 2'h1 : (i == 6) ? 2'h3 : 2'h2;
            `CHK("refuse", es, st2)
        end
        finish_test();
    end
endmodule : testbench
